// [common/smsc_pkg.sv]
// Constants and types shared by the serial memory select block
package smsc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_HALF_NS   = 40;
  localparam int BIT_HALF_CYC  = (BIT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_W        = 22;
  localparam int CHIP_LOG      = 20;
  localparam int LOG_256K      = 18;
  localparam int LOG_512K      = 19;
  localparam int LOG_1M        = 20;
  localparam int LOG_TWO       = 21;
  localparam int LOG_FOUR      = 22;

  typedef enum logic [2:0]
  {
    CFG_256K = 3'h0,
    CFG_512K = 3'h1,
    CFG_1M   = 3'h2,
    CFG_TWO  = 3'h3,
    CFG_FOUR = 3'h4
  } smsc_cfg_type;

  typedef enum logic
  {
    MODE_STANDALONE = 1'b0,
    MODE_HOST       = 1'b1
  } smsc_mode_type;

  typedef enum logic [2:0]
  {
    ST_PDN  = 3'h1,
    ST_LOW  = 3'h2,
    ST_HIGH = 3'h4
  } smsc_state_type;

  typedef struct packed
  {
    smsc_mode_type mode;
    smsc_cfg_type  cfg;
  } smsc_strap_type;

  localparam smsc_strap_type STRAP_RST = '{mode: MODE_STANDALONE, cfg: CFG_256K};
endpackage

// [src/smsc_buf2.sv]
// Two-entry buffer with valid and ready on both sides
module smsc_buf2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             clkEn,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  logic [WIDTH-1:0] slot_r [2];
  logic             rdPtr_r;
  logic             wrPtr_r;
  logic [1:0]       count_r;
  logic             push;
  logic             pop;

  assign inReady  = (count_r != 2'h2);
  assign outValid = (count_r != 2'h0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = slot_r[rdPtr_r];

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rdPtr_r <= 1'b0;
      wrPtr_r <= 1'b0;
      count_r <= 2'h0;
    end
    else if (clkEn)
    begin
      if (push)
        wrPtr_r <= ~wrPtr_r;
      if (pop)
        rdPtr_r <= ~rdPtr_r;
      if (push && !pop)
        count_r <= count_r + 2'h1;
      else if (pop && !push)
        count_r <= count_r - 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      slot_r[0] <= '0;
      slot_r[1] <= '0;
    end
    else if (clkEn && push)
      slot_r[wrPtr_r] <= inData;
  end
endmodule // smsc_buf2

// [src/smsc_mem_select.sv]
// Pin roles, strap decode and bit transfer toward serial memories
// Summary of operation
// - One two-way data pin: driven while writing memory, sampled while reading.
// - One active-low select per memory; only the accessed memory's select is low.
// - Third select is a select in four-memory mode, else high-at-powerdown standby.
// - Fourth select is driven in four-memory mode, else input for strap low bit.
// - Three count straps decode to five configurations limiting address and selects.
// - Mode strap low means stand-alone, high means host command mode; held fixed.
// - Reset clears all state; leave power-down only after release and a request.
// - Write-enable output picks read or write; bit clock times each data bit.
module smsc_mem_select (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  clkEn,
  // Straps
  input  wire logic                  hostModeStrap,
  input  wire logic                  memCountStrapMid,
  input  wire logic                  memCountStrapHi,
  // Operation request
  input  wire logic                  opStart,
  input  wire logic                  opWrite,
  input  wire logic                  opStop,
  // Status
  output logic                       busy,
  output logic                       memFull,
  output smsc_pkg::smsc_strap_type   strapOut,
  // Write stream
  input  wire logic                  wrValid,
  input  wire logic                  wrData,
  output logic                       wrReady,
  // Read stream
  output logic                       rdValid,
  output logic                       rdData,
  input  wire logic                  rdReady,
  // Memory pins
  output logic                       memSelectAN,
  output logic                       memSelectBN,
  output logic                       memSelectCN,
  input  wire logic                  memSelectDIn,
  output logic                       memSelectDOut,
  output logic                       memSelectDOeN,
  input  wire logic                  memDataIn,
  output logic                       memDataOut,
  output logic                       memDataOeN,
  output logic                       memWriteEnN,
  output logic                       memBitClock
);
  localparam logic [2:0] HALF_LAST = 3'(smsc_pkg::BIT_HALF_CYC - 1);

  smsc_pkg::smsc_state_type  state_r;
  smsc_pkg::smsc_strap_type  strap_r;
  logic                      strapDone_r;
  logic                      writeMode_r;
  logic [2:0]                halfCnt_r;
  logic [smsc_pkg::ADDR_W-1:0] addr_r;
  logic [smsc_pkg::ADDR_W-1:0] lastAddr;
  logic [1:0]                chip;
  logic                      halfDone;
  logic                      active;
  logic                      fourMode;
  logic                      bufInReady;
  logic                      bufPush;
  logic                      stepUp;
  logic                      atLast;
  logic                      memFull_r;
  logic                      memDataOut_r;

  function automatic smsc_pkg::smsc_cfg_type decodeCfg(input logic hi, input logic mid,
                                                       input logic lo);
    case ({hi, mid})
      2'b00:   decodeCfg = lo ? smsc_pkg::CFG_512K : smsc_pkg::CFG_256K;
      2'b01:   decodeCfg = smsc_pkg::CFG_1M;
      2'b10:   decodeCfg = smsc_pkg::CFG_TWO;
      default: decodeCfg = smsc_pkg::CFG_FOUR;
    endcase
  endfunction

  function automatic int capLog(input smsc_pkg::smsc_cfg_type c);
    case (c)
      smsc_pkg::CFG_256K: capLog = smsc_pkg::LOG_256K;
      smsc_pkg::CFG_512K: capLog = smsc_pkg::LOG_512K;
      smsc_pkg::CFG_1M:   capLog = smsc_pkg::LOG_1M;
      smsc_pkg::CFG_TWO:  capLog = smsc_pkg::LOG_TWO;
      default:            capLog = smsc_pkg::LOG_FOUR;
    endcase
  endfunction

  // Straps caught on the first enabled edge after reset release
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_r     <= smsc_pkg::STRAP_RST;
      strapDone_r <= 1'b0;
    end
    else if (clkEn && !strapDone_r)
    begin
      strap_r.mode <= smsc_pkg::smsc_mode_type'(hostModeStrap);
      strap_r.cfg  <= decodeCfg(memCountStrapHi, memCountStrapMid, memSelectDIn);
      strapDone_r  <= 1'b1;
    end
  end

  assign fourMode = strapDone_r && (strap_r.cfg == smsc_pkg::CFG_FOUR);
  assign lastAddr = {smsc_pkg::ADDR_W{1'b1}} >> (smsc_pkg::ADDR_W - capLog(strap_r.cfg));
  assign chip     = addr_r[smsc_pkg::ADDR_W-1:smsc_pkg::CHIP_LOG];
  assign active   = (state_r != smsc_pkg::ST_PDN);
  assign halfDone = (halfCnt_r == HALF_LAST);
  assign atLast   = (addr_r == lastAddr);
  assign stepUp   = (state_r == smsc_pkg::ST_LOW) && halfDone && !opStop &&
                    (writeMode_r ? wrValid : bufInReady);
  assign bufPush  = (state_r == smsc_pkg::ST_HIGH) && halfDone && !writeMode_r;
  assign wrReady  = stepUp && writeMode_r;

  // Bit sequencer: power-down, clock low phase, clock high phase
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r     <= smsc_pkg::ST_PDN;
      writeMode_r <= 1'b0;
      halfCnt_r   <= 3'h0;
      addr_r      <= '0;
      memFull_r   <= 1'b0;
    end
    else if (clkEn)
    begin
      case (state_r)
        smsc_pkg::ST_PDN:
        begin
          halfCnt_r <= 3'h0;
          if (strapDone_r && opStart)
          begin
            state_r     <= smsc_pkg::ST_LOW;
            writeMode_r <= opWrite;
            addr_r      <= '0;
            memFull_r   <= 1'b0;
          end
        end
        smsc_pkg::ST_LOW:
        begin
          if (opStop)
            state_r <= smsc_pkg::ST_PDN;
          else if (stepUp)
          begin
            state_r   <= smsc_pkg::ST_HIGH;
            halfCnt_r <= 3'h0;
          end
          else if (!halfDone)
            halfCnt_r <= halfCnt_r + 3'h1;
        end
        smsc_pkg::ST_HIGH:
        begin
          if (!halfDone)
            halfCnt_r <= halfCnt_r + 3'h1;
          else
          begin
            halfCnt_r <= 3'h0;
            if (atLast)
            begin
              state_r   <= smsc_pkg::ST_PDN;
              memFull_r <= 1'b1;
            end
            else
            begin
              state_r <= smsc_pkg::ST_LOW;
              addr_r  <= addr_r + 1'b1;
            end
          end
        end
        default: state_r <= smsc_pkg::ST_PDN;
      endcase
    end
  end

  // Write bit presented ahead of the rising bit clock
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      memDataOut_r <= 1'b0;
    else if (clkEn && wrReady)
      memDataOut_r <= wrData;
  end

  smsc_buf2 #(
    .WIDTH (1)
  ) u_rdBuf (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .clkEn    (clkEn),
    .inValid  (bufPush),
    .inData   (memDataIn),
    .inReady  (bufInReady),
    .outValid (rdValid),
    .outData  (rdData),
    .outReady (rdReady)
  );

  assign memDataOut    = memDataOut_r;
  assign memDataOeN    = !(active && writeMode_r);
  assign memWriteEnN   = !(active && writeMode_r);
  // Rises one cycle into the high phase so the write bit set up on the previous edge
  assign memBitClock   = (state_r == smsc_pkg::ST_HIGH) && (halfCnt_r != 3'h0);
  assign memSelectAN   = !(active && chip == 2'h0);
  assign memSelectBN   = !(active && chip == 2'h1);
  assign memSelectCN   = fourMode ? !(active && chip == 2'h2) : !active;
  assign memSelectDOut = !(active && chip == 2'h3);
  assign memSelectDOeN = !fourMode;
  assign busy          = active;
  assign memFull       = memFull_r;
  assign strapOut      = strap_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  selOneLow_a: assert property (
    $countones({memSelectAN, memSelectBN, fourMode ? memSelectCN : 1'b1,
                fourMode ? memSelectDOut : 1'b1}) >= 3)
    else $error("more than one memory select low");
  selIdle_a: assert property (!active |-> memSelectAN && memSelectBN)
    else $error("select low while powered down");
  standbyPin_a: assert property (strapDone_r && !fourMode |-> memSelectCN == !busy)
    else $error("standby pin does not follow power-down");
  strapInput_a: assert property (strapDone_r && !fourMode |-> memSelectDOeN)
    else $error("fourth select driven outside four-memory mode");
  dataDrive_a: assert property ($rose(busy) |->
    memDataOeN == !$past(opWrite) && memWriteEnN == !$past(opWrite))
    else $error("data pin drive does not match write mode");
  resetPdn_a: assert property ($rose(nrst) |-> !busy && memSelectAN)
    else $error("not in power-down after reset");
  startWait_a: assert property (!busy && !(opStart && strapDone_r) && clkEn |=> !busy)
    else $error("left power-down without a request");
  clkHigh_a: assert property (clkEn && $rose(memBitClock) |-> memBitClock [*3])
    else $error("bit clock high phase too short");
  oneChip_a: assert property (strapDone_r && strap_r.cfg <= smsc_pkg::CFG_1M |-> memSelectBN)
    else $error("second select used in one-memory config");
  modeHold_a: assert property (strapDone_r && $past(strapDone_r) |-> $stable(strap_r))
    else $error("strap state changed after capture");

  writeRun_c: cover property (busy && !memWriteEnN && wrReady);
  readRun_c:  cover property (bufPush ##[1:20] rdValid && rdReady);
  secondChip_c: cover property (!memSelectBN);
  fullStop_c: cover property ($rose(memFull));
endmodule // smsc_mem_select

// [sim/smsc_serial_mem.sv]
// Behavioural serial memory chip on the select, bit clock and data pins
module smsc_serial_mem (
  // Memory pins
  input  wire logic selN,
  input  wire logic writeEnN,
  input  wire logic bitClock,
  input  wire logic dataPin,
  output logic      dataDrive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] memR  = 16'h0000;
  logic [3:0]  idxR  = 4'h0;
  logic        lastR = 1'b0;
  // Bit is stored on the rising bit clock while writing
  always @(posedge bitClock)
    if (!selN && !writeEnN)
      memR[idxR] <= dataPin;
  // Address restarts whenever the chip is deselected
  always @(negedge bitClock or posedge selN)
    if (selN)
      idxR <= 4'h0;
    else
    begin
      lastR <= memR[idxR];
      idxR  <= idxR + 4'h1;
    end
  // Released line shows the inverse of the last bit, never a stale copy
  assign dataDrive = (!selN && writeEnN) ? memR[idxR] : ~lastR;
endmodule // smsc_serial_mem

// [sim/smsc_mem_select_bench.sv]
// Self-checking bench for the serial memory select block
`define CHK(act, exp) begin tests_run++; if ((act) !== (exp)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, act, exp); end end
module smsc_mem_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic hostModeStrap = 1'b0, strapHi = 1'b0, strapMid = 1'b0, strapLo = 1'b0;
  logic opStart = 1'b0, opWrite = 1'b0, opStop = 1'b0;
  logic wrValid = 1'b0, wrData = 1'b0, rdReady = 1'b0;
  logic clkEn = 1'b1;
  logic busy, memFull, rdValid, rdData, wrReady, selAN, selBN, selCN;
  logic selDOut, selDOeN, selDIn, dataIn, dataOut, dataOeN, weN, bitClk, memDrive;
  smsc_pkg::smsc_strap_type strapOut;
  int fails = 0;
  int tests_run = 0;
  logic [3:0] got;
  // Straps hi, mid, lo, mode and the captured strap word
  logic [7:0] rows [6] = '{8'h00, 8'h21, 8'h42, 8'h9B, 8'hC4, 8'hDC};
  assign selDIn = selDOeN ? strapLo : selDOut;
  assign dataIn = dataOeN ? memDrive : dataOut;
  always #5 clk_sys = ~clk_sys;
  smsc_mem_select u_smsc_mem_select (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn),
    .hostModeStrap(hostModeStrap), .memCountStrapMid(strapMid), .memCountStrapHi(strapHi),
    .opStart(opStart), .opWrite(opWrite), .opStop(opStop), .busy(busy), .memFull(memFull),
    .strapOut(strapOut), .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady),
    .rdValid(rdValid), .rdData(rdData), .rdReady(rdReady), .memSelectAN(selAN),
    .memSelectBN(selBN), .memSelectCN(selCN), .memSelectDIn(selDIn),
    .memSelectDOut(selDOut), .memSelectDOeN(selDOeN), .memDataIn(dataIn),
    .memDataOut(dataOut), .memDataOeN(dataOeN), .memWriteEnN(weN), .memBitClock(bitClk));
  smsc_serial_mem u_smsc_serial_mem (.selN(selAN), .writeEnN(weN), .bitClock(bitClk),
    .dataPin(dataIn), .dataDrive(memDrive));
  task finish_test();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task doReset(input logic [3:0] s);
    @(negedge clk_sys);
    {strapHi, strapMid, strapLo, hostModeStrap} = s;
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK({busy, selAN, dataOeN, weN}, 4'h7)
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
  endtask
  task startOp(input logic w);
    opWrite = w;
    opStart = 1'b1;
    @(negedge clk_sys);
    opStart = 1'b0;
    `CHK(busy, 1'b1)
  endtask
  task stopOp();
    int n;
    n = 0;
    opStop = 1'b1;
    while (busy !== 1'b0 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    opStop = 1'b0;
    `CHK({busy, selAN, selCN, weN, memFull}, 5'h0E)
  endtask
  task sendBit(input logic b);
    int n;
    n = 0;
    wrValid = 1'b1;
    wrData = b;
    #1;
    while (wrReady !== 1'b1 && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
  endtask
  task recvBit(output logic b);
    int n;
    n = 0;
    while (rdValid !== 1'b1 && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
    b = rdData;
    @(negedge clk_sys);
  endtask
  initial
  begin
    #200000;
    fails++;
    finish_test();
  end
  initial
  begin
    foreach (rows[i])
    begin
      doReset(rows[i][7:4]);
      `CHK(strapOut, rows[i][3:0])
      `CHK(selCN, 1'b1)
      `CHK(selDOeN, rows[i][7:6] != 2'h3)
    end
    startOp(1'b1);
    `CHK({selAN, selBN, selCN, selDOut, selDOeN}, 5'h0E)
    stopOp();
    doReset(4'h4);
    startOp(1'b1);
    `CHK({weN, dataOeN, selAN, selBN, selCN}, 5'h02)
    foreach (got[i])
      sendBit(i != 1);
    wrValid = 1'b0;
    stopOp();
    // A request while the clock enable is low must not leave power-down
    clkEn = 1'b0;
    opStart = 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK(busy, 1'b0)
    clkEn = 1'b1;
    opStart = 1'b0;
    @(negedge clk_sys);
    startOp(1'b0);
    `CHK({weN, dataOeN, selAN, selBN}, 4'hD)
    repeat (100) @(negedge clk_sys);
    `CHK({rdValid, bitClk, busy}, 3'h5)
    rdReady = 1'b1;
    foreach (got[i])
      recvBit(got[i]);
    `CHK(got, 4'hD)
    stopOp();
    finish_test();
  end
endmodule // smsc_mem_select_bench
